// ===== logic/sfo_defines.vh
// How it works
// - Reading a force bit returns raw comparator state
// - Overvolt enable set: written bits feed debounce
// - First register: conv 6,4,3,1 at bits 5,3,2,0
// - Undervolt enable set: written bits feed debounce
// - Overcurrent enable set: written bit feeds debounce
// - Second register: bit 15, bits 11:8, bits 5:0
`ifndef SFO_DEFINES_VH
`define SFO_DEFINES_VH
`define SFO_OFS_OVERVOLT   8'he4
`define SFO_OFS_UNDERVOLT  8'he5
`define SFO_IDX_OVERVOLT   8'he4
`define SFO_IDX_UNDERVOLT  8'he5
`define SFO_ADDR_OVERVOLT  12'h390
`define SFO_ADDR_UNDERVOLT 12'h394
`define SFO_ADDR_ENABLE    12'h3a0
`define SFO_ADDR_IRQ_STAT  12'h3a4
`define SFO_ADDR_IRQ_MASK  12'h3a8
`define SFO_OV_MASK        16'h002d
`define SFO_UV_MASK        16'h8f3f
`define SFO_UV_GROUP_MASK  16'h0f3f
`define SFO_OC_BIT         15
`define SFO_EN_OV_BIT      0
`define SFO_EN_UV_BIT      1
`define SFO_EN_OC_BIT      2
`define SFO_RESET_VALUE    16'h0000
`endif

// ===== logic/sfo_force_mux.v
`timescale 1ns/1ps
// Per-bit choice between the real comparator and the software value
module sfo_force_mux (
    // Selection
    input  wire [15:0] group_sel,
    input  wire [15:0] real_level,
    input  wire [15:0] forced_level,
    // Result
    output wire [15:0] debounce_in
);
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_bit
            assign debounce_in[i] = group_sel[i] ? forced_level[i] : real_level[i];
        end
    endgenerate
endmodule // sfo_force_mux

// ===== logic/sfo_regs.v
`timescale 1ns/1ps
`include "sfo_defines.vh"
module sfo_regs (
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Raw comparators, asynchronous to clk
    input  wire [15:0] overvolt_comp,
    input  wire [15:0] undervolt_overcurrent_comp,
    // Debounce inputs
    output reg  [15:0] overvolt_debounce_in,
    output reg  [15:0] undervolt_overcurrent_debounce_in,
    // Interrupt
    output reg         irq
);
    reg  [15:0] supply_overvoltage_override;
    reg  [15:0] supply_undervoltage_overcurrent_override;
    reg  [2:0]  force_enable;
    reg  [1:0]  irq_status;
    reg  [1:0]  irq_mask;
    reg  [15:0] ov_prev;
    reg  [15:0] uv_prev;
    reg         seen;
    wire [15:0] ov_raw;
    wire [15:0] uv_raw;
    wire [15:0] ov_sync;
    wire [15:0] uv_sync;
    wire [15:0] ov_sel;
    wire [15:0] uv_sel;
    wire [15:0] next_ov_deb;
    wire [15:0] next_uv_deb;
    wire        overvolt_group_force_enable;
    wire        undervolt_group_force_enable;
    wire        overcurrent_group_force_enable;
    wire        access;
    wire        wr;
    wire        mapped;
    wire [1:0]  next_event;
    reg  [31:0] next_rdata;

    assign overvolt_group_force_enable    = force_enable[`SFO_EN_OV_BIT];
    assign undervolt_group_force_enable   = force_enable[`SFO_EN_UV_BIT];
    assign overcurrent_group_force_enable = force_enable[`SFO_EN_OC_BIT];

    // Comparators are analog and asynchronous
    sfo_sync #(.WIDTH(16)) u_sync_ov (
        .clk    (clk),
        .resetn (resetn),
        .din    (overvolt_comp),
        .dout   (ov_sync)
    );
    sfo_sync #(.WIDTH(16)) u_sync_uv (
        .clk    (clk),
        .resetn (resetn),
        .din    (undervolt_overcurrent_comp),
        .dout   (uv_sync)
    );

    // Unused bits dropped after the second stage, so no gate sees a raw pin
    assign ov_raw = ov_sync & `SFO_OV_MASK;
    assign uv_raw = uv_sync & `SFO_UV_MASK;

    assign ov_sel = {16{overvolt_group_force_enable}} & `SFO_OV_MASK;
    assign uv_sel = ({16{undervolt_group_force_enable}} & `SFO_UV_GROUP_MASK) |
                    ({16{overcurrent_group_force_enable}} & (16'h0001 << `SFO_OC_BIT));

    sfo_force_mux u_mux_ov (
        .group_sel    (ov_sel),
        .real_level   (ov_raw),
        .forced_level (supply_overvoltage_override),
        .debounce_in  (next_ov_deb)
    );
    sfo_force_mux u_mux_uv (
        .group_sel    (uv_sel),
        .real_level   (uv_raw),
        .forced_level (supply_undervoltage_overcurrent_override),
        .debounce_in  (next_uv_deb)
    );

    assign access = psel & penable;
    assign wr     = access & pwrite;
    assign mapped = (paddr == `SFO_ADDR_OVERVOLT) || (paddr == `SFO_ADDR_UNDERVOLT) ||
                    (paddr == `SFO_ADDR_ENABLE) || (paddr == `SFO_ADDR_IRQ_STAT) ||
                    (paddr == `SFO_ADDR_IRQ_MASK);

    // Events: any change of the debounce feed per register
    assign next_event = seen ? {|(next_uv_deb ^ uv_prev), |(next_ov_deb ^ ov_prev)} : 2'b00;

    always @* begin
        next_rdata = 32'h00000000;
        case (paddr)
            `SFO_ADDR_OVERVOLT:  next_rdata = {16'h0000, ov_raw & `SFO_OV_MASK};
            `SFO_ADDR_UNDERVOLT: next_rdata = {16'h0000, uv_raw & `SFO_UV_MASK};
            `SFO_ADDR_ENABLE:    next_rdata = {29'h0, force_enable};
            `SFO_ADDR_IRQ_STAT:  next_rdata = {30'h0, irq_status};
            `SFO_ADDR_IRQ_MASK:  next_rdata = {30'h0, irq_mask};
            default:             next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            supply_overvoltage_override              <= `SFO_RESET_VALUE;
            supply_undervoltage_overcurrent_override <= `SFO_RESET_VALUE;
            force_enable <= 3'h0;
            irq_mask     <= 2'h0;
            prdata       <= 32'h00000000;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
        end else begin
            // One wait state: answer on the second access cycle
            pready  <= access & ~pready;
            pslverr <= access & ~pready & ~mapped;
            if (access & ~pready & ~pwrite) begin
                prdata <= next_rdata;
            end
            if (wr & pready) begin
                case (paddr)
                    `SFO_ADDR_OVERVOLT: begin
                        supply_overvoltage_override <= pwdata[15:0] & `SFO_OV_MASK;
                    end
                    `SFO_ADDR_UNDERVOLT: begin
                        supply_undervoltage_overcurrent_override <= pwdata[15:0] & `SFO_UV_MASK;
                    end
                    `SFO_ADDR_ENABLE:   force_enable <= pwdata[2:0];
                    `SFO_ADDR_IRQ_MASK: irq_mask <= pwdata[1:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Sticky events; a new event wins over a write-one clear
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_status <= 2'h0;
            ov_prev    <= 16'h0000;
            uv_prev    <= 16'h0000;
            seen       <= 1'b0;
            overvolt_debounce_in              <= 16'h0000;
            undervolt_overcurrent_debounce_in <= 16'h0000;
            irq <= 1'b0;
        end else begin
            seen    <= 1'b1;
            ov_prev <= next_ov_deb;
            uv_prev <= next_uv_deb;
            overvolt_debounce_in              <= next_ov_deb;
            undervolt_overcurrent_debounce_in <= next_uv_deb;
            if (wr & pready & (paddr == `SFO_ADDR_IRQ_STAT)) begin
                irq_status <= (irq_status & ~pwdata[1:0]) | next_event;
            end else begin
                irq_status <= irq_status | next_event;
            end
            irq <= |(irq_status & irq_mask);
        end
    end
endmodule // sfo_regs

// ===== logic/sfo_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser; only the second stage is visible outside
module sfo_sync #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input  wire             clk,
    input  wire             resetn,
    // Data
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] stage1;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= {WIDTH{1'b0}};
            dout   <= {WIDTH{1'b0}};
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // sfo_sync

// ===== verif/sfo_regs_props.sv
`timescale 1ns/1ps
`include "sfo_defines.vh"
module sfo_regs_props (
    // Clock and reset
    input wire        clk,
    input wire        resetn,
    // APB slave
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Comparators and debounce feeds
    input wire [15:0] overvolt_comp,
    input wire [15:0] undervolt_overcurrent_comp,
    input wire [15:0] overvolt_debounce_in,
    input wire [15:0] undervolt_overcurrent_debounce_in,
    // Interrupt
    input wire        irq
);
    // Force values are write-only, so they and the enables are mirrored here from completed writes
    reg  [2:0]  en;
    reg  [15:0] fov, fuv;
    wire        done = psel & penable & pready;
    wire        mapped = paddr == `SFO_ADDR_OVERVOLT || paddr == `SFO_ADDR_UNDERVOLT ||
                paddr == `SFO_ADDR_ENABLE || paddr == `SFO_ADDR_IRQ_STAT ||
                paddr == `SFO_ADDR_IRQ_MASK;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            en <= 3'h0;
            fov <= 16'h0000;
            fuv <= 16'h0000;
        end else if (done & pwrite) begin
            if (paddr == `SFO_ADDR_ENABLE) en <= pwdata[2:0];
            if (paddr == `SFO_ADDR_OVERVOLT) fov <= pwdata[15:0];
            if (paddr == `SFO_ADDR_UNDERVOLT) fuv <= pwdata[15:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held over one cycle");
    wait_state_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait state");
    unmapped_err_a: assert property (done |-> pslverr == !mapped)
        else $error("pslverr does not match the address map");
    ov_force_a: assert property ($past(en[0]) |->
        overvolt_debounce_in == ($past(fov) & `SFO_OV_MASK)) else $error("ov feed not forced");
    uv_force_a: assert property ($past(en[1]) |->
        (undervolt_overcurrent_debounce_in & `SFO_UV_GROUP_MASK) ==
        ($past(fuv) & `SFO_UV_GROUP_MASK)) else $error("uv feed not forced");
    oc_force_a: assert property ($past(en[2]) |->
        undervolt_overcurrent_debounce_in[15] == $past(fuv[15])) else $error("oc feed not forced");
    ov_real_a: assert property (!$past(en[0]) |->
        overvolt_debounce_in == ($past(overvolt_comp, 3) & `SFO_OV_MASK))
        else $error("ov feed not from comparators");
    uv_real_a: assert property (!$past(en[1]) |->
        (undervolt_overcurrent_debounce_in & `SFO_UV_GROUP_MASK) ==
        ($past(undervolt_overcurrent_comp, 3) & `SFO_UV_GROUP_MASK))
        else $error("uv feed not from comparators");
    oc_real_a: assert property (!$past(en[2]) |->
        undervolt_overcurrent_debounce_in[15] == $past(undervolt_overcurrent_comp[15], 3))
        else $error("oc feed not from comparator");
    ov_read_raw_a: assert property (done && !pwrite && paddr == `SFO_ADDR_OVERVOLT |->
        prdata[15:0] == ($past(overvolt_comp, 3) & `SFO_OV_MASK))
        else $error("ov read not raw comparator");
    cover property (done && pslverr);
    cover property (en == 3'h7);
    cover property (irq);
endmodule // sfo_regs_props
bind sfo_regs sfo_regs_props u_props (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .irq(irq),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .overvolt_comp(overvolt_comp),
    .undervolt_overcurrent_comp(undervolt_overcurrent_comp),
    .overvolt_debounce_in(overvolt_debounce_in),
    .undervolt_overcurrent_debounce_in(undervolt_overcurrent_debounce_in));

// ===== verif/sfo_regs_tb.sv
`timescale 1ns/1ps
`include "sfo_defines.vh"
module sfo_regs_tb;
    reg         clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0, rd;
    reg  [15:0] ovc = 16'h0000, uvc = 16'h0000, eov, euv;
    wire [31:0] prdata;
    wire        pready, pslverr, irq;
    wire [15:0] ovd, uvd;
    integer     fails = 0, total_checks = 0, i;
    always #12.5 clk = ~clk;
    sfo_regs uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .overvolt_comp(ovc), .undervolt_overcurrent_comp(uvc),
        .overvolt_debounce_in(ovd), .undervolt_overcurrent_debounce_in(uvd), .irq(irq));
    task finish_test; begin
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    end endtask
    task chk(input [8*12:1] nm, input [31:0] exp, input [31:0] got); begin
        total_checks = total_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("FAIL %0s expected %h seen %h", nm, exp, got);
        end
    end endtask
    task apb(input w, input [11:0] a, input [31:0] d); begin
        @(posedge clk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk); penable <= 1;
        // Wait for the answer; only the watchdog ends a hung transfer
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    end endtask
    initial begin #100000; fails = fails + 1; finish_test; end
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1;
        apb(0, `SFO_ADDR_OVERVOLT, 0); chk("ov default", 32'h0, rd);
        apb(0, `SFO_ADDR_UNDERVOLT, 0); chk("uv default", 32'h0, rd);
        // Written force values differ from the raw levels so readback shows which one
        apb(1, `SFO_ADDR_OVERVOLT, 32'hffff000b);
        apb(1, `SFO_ADDR_UNDERVOLT, 32'h000005ea);
        ovc <= 16'hffe4; uvc <= 16'hfa15;
        repeat (5) @(posedge clk);
        apb(0, `SFO_ADDR_OVERVOLT, 0); chk("ov raw", ovc & `SFO_OV_MASK, rd);
        apb(0, `SFO_ADDR_UNDERVOLT, 0); chk("uv raw", uvc & `SFO_UV_MASK, rd);
        for (i = 0; i < 8; i = i + 1) begin
            apb(1, `SFO_ADDR_ENABLE, i);
            repeat (2) @(posedge clk);
            // Outputs are looked at mid-cycle, away from the launching edge
            @(negedge clk);
            eov = (i[0] ? 16'h000b : ovc) & `SFO_OV_MASK;
            euv = ((i[1] ? 16'h05ea : uvc) & `SFO_UV_GROUP_MASK) | ((i[2] ? 16'h0 : uvc) & 16'h8000);
            chk("ov feed", eov, ovd);
            chk("uv oc feed", euv, uvd);
        end
        apb(1, `SFO_ADDR_ENABLE, 0);
        repeat (5) @(posedge clk);
        apb(1, `SFO_ADDR_IRQ_STAT, 3);
        apb(1, `SFO_ADDR_IRQ_MASK, 2);
        ovc <= 16'h0001;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("irq masked", 0, irq);
        apb(0, `SFO_ADDR_IRQ_STAT, 0); chk("irq status", 32'h1, rd);
        apb(1, `SFO_ADDR_IRQ_MASK, 3);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("irq raised", 1, irq);
        apb(1, `SFO_ADDR_IRQ_STAT, 1);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("irq cleared", 0, irq);
        apb(0, 12'h3fc, 0); chk("unmap err", 1, err);
        chk("unmap data", 32'h0, rd);
        finish_test;
    end
endmodule // sfo_regs_tb
